//--- inc/uc3_regs.svh
// Register offsets, field positions and reset values of the control block.
`ifndef UC3_REGS_SVH
`define UC3_REGS_SVH

`define UC3_OFS_MODE        4'h0
`define UC3_OFS_DATA        4'h1
`define UC3_OFS_ERR_STATUS  4'h2
`define UC3_OFS_STATE       4'h3
`define UC3_OFS_CTRL_THREE  4'h6

`define UC3_MODE_NINE_BIT   0
`define UC3_MODE_LOOP       1
`define UC3_MODE_RX_SOURCE  2

`define UC3_C3_RX_NINTH     7
`define UC3_C3_TX_NINTH     6
`define UC3_C3_PIN_DIR      5
`define UC3_C3_TX_INVERT    4
`define UC3_C3_OVERRUN_EN   3
`define UC3_C3_NOISE_EN     2
`define UC3_C3_FRAMING_EN   1
`define UC3_C3_PARITY_EN    0

`define UC3_ERR_OVERRUN     3
`define UC3_ERR_NOISE       2
`define UC3_ERR_FRAMING     1
`define UC3_ERR_PARITY      0

`define UC3_STATE_RX_FULL   0

`define UC3_RESET_BYTE      8'h00
`define UC3_RESET_ERR       4'h0
`define UC3_RESET_NINE      9'h000

`endif

//--- inc/uc3_pkg.sv
// Types shared by the control register block.
package uc3_pkg;
  typedef logic [3:0] uc3_addr_t;
  typedef logic [7:0] uc3_byte_t;
  typedef logic [3:0] uc3_err_t;
  typedef logic [8:0] uc3_char_t;
endpackage

//--- verilog/uc3_irq.sv
// Sticky error status with write-one-to-clear and a masked interrupt line.
`timescale 1ns/10ps
`include "uc3_regs.svh"

module uc3_irq
(
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire uc3_pkg::uc3_err_t events,
  input  wire logic             clear_write,
  input  wire uc3_pkg::uc3_err_t clear_bits,
  input  wire uc3_pkg::uc3_err_t enables,
  output uc3_pkg::uc3_err_t     status,
  output logic                  irq
);
  import uc3_pkg::*;

  uc3_err_t next_status;
  logic     next_irq;

  always_comb
  begin
    next_status = status;
    if (clear_write)
    begin
      next_status = next_status & ~clear_bits;
    end
    // A new event in the clearing cycle survives the clear.
    next_status = next_status | events;
    next_irq    = |(next_status & enables);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status <= `UC3_RESET_ERR;
      irq    <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq    <= next_irq;
    end
  end
endmodule // uc3_irq

//--- verilog/uc3_ctrl.sv
// Third serial control register with ninth bits, pin control and error irq.
//
// How it works
// RL1 - Control register three sits at offset 6h, all bits reset to zero.
// RL2 - In nine-bit mode bit 7 shows the ninth received data bit.
// RL3 - Software reads the ninth bit before the data register read.
// RL4 - Data write moves ninth transmit bit plus data byte to the shifter.
// RL5 - Ninth transmit bit is held across data writes; software updates it.
// RL6 - In single-wire mode bit 5 sets transmit pin direction.
// RL7 - Bit 4 inverts every transmitted element including break and idle.
// RL8 - Bit 3 lets a set overrun flag raise the interrupt.
// RL9 - Bit 2 lets a set noise flag raise the interrupt.
// RL10 - Bit 1 lets a set framing error flag raise the interrupt.
// RL11 - Bit 0 lets a set parity error flag raise the interrupt.
// RL12 - Ninth received bit loads with the byte; writes to it are ignored.
`timescale 1ns/10ps
`include "uc3_regs.svh"

module uc3_ctrl
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire uc3_pkg::uc3_addr_t addr,
  input  wire uc3_pkg::uc3_byte_t wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output uc3_pkg::uc3_byte_t     rdata,
  input  wire logic              rx_char_valid,
  input  wire uc3_pkg::uc3_char_t rx_char,
  input  wire logic              overrun_event,
  input  wire logic              noise_event,
  input  wire logic              framing_event,
  input  wire logic              parity_event,
  output logic                   tx_load,
  output uc3_pkg::uc3_char_t     tx_shift_data,
  input  wire logic              tx_raw_bit,
  output logic                   txd_out,
  output logic                   txd_oe,
  output logic                   nine_bit_mode,
  output logic                   loop_select,
  output logic                   receiver_source_select,
  output logic                   irq
);
  import uc3_pkg::*;

  uc3_byte_t serial_control_three;
  uc3_byte_t next_serial_control_three;
  logic      next_nine_bit_mode;
  logic      next_loop_select;
  logic      next_receiver_source_select;
  uc3_byte_t rx_data;
  uc3_byte_t next_rx_data;
  logic      rx_ninth_bit;
  logic      next_rx_ninth_bit;
  logic      rx_full;
  logic      next_rx_full;
  logic      next_tx_load;
  uc3_char_t next_tx_shift_data;
  logic      next_txd_out;
  logic      next_txd_oe;
  uc3_byte_t next_rdata;
  uc3_err_t  err_status;
  uc3_err_t  err_events;
  logic      single_wire;
  logic      wr_c3;
  logic      wr_mode;
  logic      wr_data;
  logic      wr_err;
  logic      rd_data;

  always_comb
  begin
    wr_c3   = 1'b0;
    wr_mode = 1'b0;
    wr_data = 1'b0;
    wr_err  = 1'b0;
    rd_data = 1'b0;
    if (addr == `UC3_OFS_CTRL_THREE)
    begin
      wr_c3 = wr_stb;
    end
    else if (addr == `UC3_OFS_MODE)
    begin
      wr_mode = wr_stb;
    end
    else if (addr == `UC3_OFS_DATA)
    begin
      wr_data = wr_stb;
      rd_data = rd_stb;
    end
    else if (addr == `UC3_OFS_ERR_STATUS)
    begin
      wr_err = wr_stb;
    end
  end

  // Control and mode register writes.
  always_comb
  begin
    next_serial_control_three = serial_control_three;
    next_nine_bit_mode          = nine_bit_mode;
    next_loop_select            = loop_select;
    next_receiver_source_select = receiver_source_select;
    if (wr_c3)
    begin
      // RL12 read-only bit
      next_serial_control_three[6:0] = wdata[6:0];
    end
    if (wr_mode)
    begin
      next_nine_bit_mode          = wdata[`UC3_MODE_NINE_BIT];
      next_loop_select            = wdata[`UC3_MODE_LOOP];
      next_receiver_source_select = wdata[`UC3_MODE_RX_SOURCE];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // RL1 reset to zero
      serial_control_three   <= `UC3_RESET_BYTE;
      nine_bit_mode          <= 1'b0;
      loop_select            <= 1'b0;
      receiver_source_select <= 1'b0;
    end
    else
    begin
      serial_control_three   <= next_serial_control_three;
      nine_bit_mode          <= next_nine_bit_mode;
      loop_select            <= next_loop_select;
      receiver_source_select <= next_receiver_source_select;
    end
  end

  // Receive buffer: the byte and its ninth bit load together.
  always_comb
  begin
    next_rx_data      = rx_data;
    next_rx_ninth_bit = rx_ninth_bit;
    next_rx_full      = rx_full;
    // RL3 data read clears
    if (rd_data)
    begin
      next_rx_full = 1'b0;
    end
    if (rx_char_valid)
    begin
      next_rx_data = rx_char[7:0];
      // RL12 load with byte
      next_rx_ninth_bit = nine_bit_mode & rx_char[8];
      next_rx_full      = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_data      <= `UC3_RESET_BYTE;
      rx_ninth_bit <= 1'b0;
      rx_full      <= 1'b0;
    end
    else
    begin
      rx_data      <= next_rx_data;
      rx_ninth_bit <= next_rx_ninth_bit;
      rx_full      <= next_rx_full;
    end
  end

  // Transmit load and pin control.
  always_comb
  begin
    single_wire  = loop_select & receiver_source_select;
    next_tx_load = wr_data;
    next_tx_shift_data = tx_shift_data;
    if (wr_data)
    begin
      // RL4 nine-bit transfer
      // RL5 held ninth bit
      next_tx_shift_data = {nine_bit_mode &
                            serial_control_three[`UC3_C3_TX_NINTH], wdata};
    end
    // RL7 invert all elements
    next_txd_out = tx_raw_bit ^ serial_control_three[`UC3_C3_TX_INVERT];
    next_txd_oe  = 1'b1;
    if (single_wire)
    begin
      // RL6 pin direction
      next_txd_oe = serial_control_three[`UC3_C3_PIN_DIR];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_load       <= 1'b0;
      tx_shift_data <= `UC3_RESET_NINE;
      txd_out       <= 1'b1;
      txd_oe        <= 1'b1;
    end
    else
    begin
      tx_load       <= next_tx_load;
      tx_shift_data <= next_tx_shift_data;
      txd_out       <= next_txd_out;
      txd_oe        <= next_txd_oe;
    end
  end

  // Read data for the cycle after the strobe.
  always_comb
  begin
    next_rdata = `UC3_RESET_BYTE;
    if (rd_stb)
    begin
      if (addr == `UC3_OFS_CTRL_THREE)
      begin
        next_rdata = serial_control_three;
        // RL2 ninth received bit
        next_rdata[`UC3_C3_RX_NINTH] = rx_ninth_bit;
      end
      else if (addr == `UC3_OFS_MODE)
      begin
        next_rdata = {5'h00, receiver_source_select, loop_select,
                      nine_bit_mode};
      end
      else if (addr == `UC3_OFS_DATA)
      begin
        next_rdata = rx_data;
      end
      else if (addr == `UC3_OFS_ERR_STATUS)
      begin
        next_rdata = {4'h0, err_status};
      end
      else if (addr == `UC3_OFS_STATE)
      begin
        next_rdata = {7'h00, rx_full};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= `UC3_RESET_BYTE;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  always_comb
  begin
    err_events = `UC3_RESET_ERR;
    err_events[`UC3_ERR_OVERRUN] = overrun_event;
    err_events[`UC3_ERR_NOISE]   = noise_event;
    err_events[`UC3_ERR_FRAMING] = framing_event;
    err_events[`UC3_ERR_PARITY]  = parity_event;
  end

  // RL8 overrun enable
  // RL9 noise enable
  // RL10 framing enable
  // RL11 parity enable
  uc3_irq u_irq
  (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .events      (err_events),
    .clear_write (wr_err),
    .clear_bits  (wdata[3:0]),
    .enables     (serial_control_three[3:0]),
    .status      (err_status),
    .irq         (irq)
  );
endmodule // uc3_ctrl

//--- test/uc3_line_peer.sv
// Line-side peer delivering characters and error pulses.
`timescale 1ns/10ps
module uc3_line_peer
(
  input  wire logic          sys_clk,
  output logic               rx_char_valid,
  output uc3_pkg::uc3_char_t rx_char,
  output uc3_pkg::uc3_err_t  err_ev,
  output logic               tx_raw_bit
);
  import uc3_pkg::*;
  initial {rx_char_valid, rx_char, err_ev, tx_raw_bit} = 15'h0001;
  // A toggling line shows the output inversion on every cycle.
  always @(posedge sys_clk) tx_raw_bit <= !tx_raw_bit;
  task automatic deliver(input uc3_char_t c, input uc3_err_t e);
    @(posedge sys_clk);
    {rx_char_valid, rx_char, err_ev} <= {1'b1, c, e};
    @(posedge sys_clk);
    {rx_char_valid, rx_char, err_ev} <= {1'b0, ~c, 4'h0};
  endtask
endmodule // uc3_line_peer

//--- test/uc3_ctrl_properties.sv
// Concurrent checks on the ports of the third control register block.
`timescale 1ns/10ps
module uc3_ctrl_props
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       overrun_event,
  input wire logic       noise_event,
  input wire logic       framing_event,
  input wire logic       parity_event,
  input wire logic       tx_load,
  input wire logic [8:0] tx_shift_data,
  input wire logic       tx_raw_bit,
  input wire logic       txd_out,
  input wire logic       txd_oe,
  input wire logic       nine_bit_mode,
  input wire logic       loop_select,
  input wire logic       receiver_source_select,
  input wire logic       irq
);
  logic       up, t9, dir, inv, sw;
  logic [3:0] en;
  assign sw = loop_select && receiver_source_select;
  // Shadow of the writable fields of control register three.
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
      {up, t9, dir, inv, en} <= 8'h00;
    else
    begin
      up <= 1'b1;
      if (wr_stb && addr == 4'h6)
        {t9, dir, inv, en} <= wdata[6:0];
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_c3_readback: assert property (rd_stb && addr == 4'h6 |=>
    rdata[6:0] == $past({t9, dir, inv, en}))
    else $error("readback wrong");
  a_tx_word: assert property (wr_stb && addr == 4'h1 |=> tx_load &&
    tx_shift_data == {$past(nine_bit_mode & t9), $past(wdata)})
    else $error("tx word wrong");
  a_tx_invert: assert property (up |->
    txd_out == $past(tx_raw_bit ^ inv)) else $error("tx level wrong");
  a_oe_normal: assert property (!sw && !$past(sw) |-> txd_oe)
    else $error("pin not driven");
  a_oe_single: assert property (sw && $past(sw) && dir == $past(dir)
    |-> txd_oe == dir) else $error("pin direction wrong");
  a_irq_raise: assert property (
    |({overrun_event, noise_event, framing_event, parity_event} & en)
    |=> irq) else $error("irq missing");
  a_irq_drop: assert property ($fell(irq) |->
    $past(wr_stb && addr == 4'h2) || $past(wr_stb && addr == 4'h6, 2))
    else $error("irq dropped");
  a_irq_masked: assert property (en == 4'h0 && $past(en) == 4'h0 |->
    !irq) else $error("masked irq seen");
  c_tx: cover property (tx_load);
  c_irq: cover property (irq);
  c_pin_in: cover property (!txd_oe);
endmodule // uc3_ctrl_props

//--- test/uc3_ctrl_test.sv
// Self-checking bench for the third serial control register block.
`timescale 1ns/10ps
module uc3_ctrl_test;
  import uc3_pkg::*;
  typedef struct {uc3_addr_t a; uc3_byte_t d; uc3_byte_t e;} uc3_row_s;
  logic      sys_clk, nrst, wr_stb, rd_stb, rx_char_valid, tx_raw_bit;
  logic      tx_load, txd_out, txd_oe, nine_bit_mode, loop_select, irq;
  logic      receiver_source_select;
  uc3_addr_t addr;
  uc3_byte_t wdata, rdata, v;
  uc3_char_t rx_char, tx_shift_data;
  uc3_err_t  err_ev;
  int        fail_count, checks;
  uc3_row_s  rows [5] = '{'{4'h6, 8'hFF, 8'h7F}, '{4'h6, 8'h5A, 8'h5A},
    '{4'h6, 8'h00, 8'h00}, '{4'h5, 8'hA5, 8'h00}, '{4'hF, 8'h3C, 8'h00}};
  uc3_ctrl uc3_ctrl_i
  (
    .sys_clk                (sys_clk),
    .nrst                   (nrst),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr_stb                 (wr_stb),
    .rd_stb                 (rd_stb),
    .rdata                  (rdata),
    .rx_char_valid          (rx_char_valid),
    .rx_char                (rx_char),
    .overrun_event          (err_ev[3]),
    .noise_event            (err_ev[2]),
    .framing_event          (err_ev[1]),
    .parity_event           (err_ev[0]),
    .tx_load                (tx_load),
    .tx_shift_data          (tx_shift_data),
    .tx_raw_bit             (tx_raw_bit),
    .txd_out                (txd_out),
    .txd_oe                 (txd_oe),
    .nine_bit_mode          (nine_bit_mode),
    .loop_select            (loop_select),
    .receiver_source_select (receiver_source_select),
    .irq                    (irq)
  );
  uc3_line_peer uc3_line_peer_i
  (
    .sys_clk       (sys_clk),
    .rx_char_valid (rx_char_valid),
    .rx_char       (rx_char),
    .err_ev        (err_ev),
    .tx_raw_bit    (tx_raw_bit)
  );
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input uc3_addr_t a, input uc3_byte_t d);
    @(posedge sys_clk);
    {wr_stb, addr, wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe; take them mid-cycle.
  task automatic rd(input uc3_addr_t a);
    @(posedge sys_clk);
    {rd_stb, addr} <= {1'b1, a};
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    {nrst, wr_stb, rd_stb, addr, wdata} = '0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(4'h6); chk(v, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a); chk(v, rows[i].e);
    end
    wr(4'h0, 8'h01);
    uc3_line_peer_i.deliver(9'h1A5, 4'h0);
    rd(4'h6); chk(v, 8'h80);
    wr(4'h6, 8'h00);
    rd(4'h6); chk(v, 8'h80);
    rd(4'h3); chk(v, 8'h01);
    rd(4'h1); chk(v, 8'hA5);
    rd(4'h3); chk(v, 8'h00);
    uc3_line_peer_i.deliver(9'h0C3, 4'h0);
    rd(4'h6); chk(v, 8'h00);
    wr(4'h6, 8'h40);
    wr(4'h1, 8'h55);
    #1 chk(tx_shift_data, 9'h155);
    chk(tx_load, 1'b1);
    wr(4'h1, 8'hAA);
    #1 chk(tx_shift_data, 9'h1AA);
    wr(4'h6, 8'h10);
    repeat (2) @(posedge sys_clk);
    #1 chk(txd_out, tx_raw_bit);
    wr(4'h6, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk(txd_out, !tx_raw_bit);
    wr(4'h0, 8'h06);
    wr(4'h6, 8'h20);
    repeat (2) @(posedge sys_clk);
    #1 chk(txd_oe, 1'b1);
    wr(4'h6, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk(txd_oe, 1'b0);
    wr(4'h0, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1 chk(txd_oe, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h6, 8'h01 << i);
      uc3_line_peer_i.deliver(9'h000, 4'h1 << i);
      #1 chk(irq, 1'b1);
      wr(4'h2, 8'h01 << i);
      #1 chk(irq, 1'b0);
      wr(4'h6, 8'h00);
      uc3_line_peer_i.deliver(9'h000, 4'h1 << i);
      #1 chk(irq, 1'b0);
    end
    rd(4'h2); chk(v, 8'h0F);
    wr(4'h6, 8'h0F);
    // The line follows a new mask one cycle after the register takes it.
    @(posedge sys_clk);
    #1 chk(irq, 1'b1);
    wr(4'h2, 8'h0F);
    #1 chk(irq, 1'b0);
    wr(4'h6, 8'h3F);
    nrst <= 1'b0;
    #1 chk(txd_out, 1'b1);
    chk(irq, 1'b0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    rd(4'h6); chk(v, 8'h00);
    rd(4'h0); chk(v, 8'h00);
    end_of_test();
  end
endmodule // uc3_ctrl_test
bind uc3_ctrl uc3_ctrl_props uc3_ctrl_props_i
(
  .sys_clk                (sys_clk),
  .nrst                   (nrst),
  .addr                   (addr),
  .wdata                  (wdata),
  .wr_stb                 (wr_stb),
  .rd_stb                 (rd_stb),
  .rdata                  (rdata),
  .overrun_event          (overrun_event),
  .noise_event            (noise_event),
  .framing_event          (framing_event),
  .parity_event           (parity_event),
  .tx_load                (tx_load),
  .tx_shift_data          (tx_shift_data),
  .tx_raw_bit             (tx_raw_bit),
  .txd_out                (txd_out),
  .txd_oe                 (txd_oe),
  .nine_bit_mode          (nine_bit_mode),
  .loop_select            (loop_select),
  .receiver_source_select (receiver_source_select),
  .irq                    (irq)
);
